// *** rtl/mhb_defs.svh ***
// Constants for the card-host delay-line reset and bus-test block.
`ifndef MHB_DEFS_SVH
`define MHB_DEFS_SVH

// Bit positions inside the host system configuration and delay-line words.
`define MHB_AUTOIDLE_BIT   0
`define MHB_DLL_FLAG_BIT   31

// Command indices of the bus-test pair.
`define MHB_CMD_BT_WRITE   6'h13
`define MHB_CMD_BT_READ    6'h0e

// Delay-line reset duration in functional clock cycles.
`define MHB_DLL_RST_CYC    64
// Data timeout in link clock cycles.
`define MHB_DTO_CYC        1024
// Data bus width in lines.
`define MHB_BUS_W          8
// Link cycles of a status token after its start bit (three status, end).
`define MHB_CRC_TOK_BITS   4
// Words of the bus-test pattern on the bus.
`define MHB_BT_WORDS       2

`endif

// *** rtl/mhb_pkg.sv ***
// Types shared by the card-host delay-line reset and bus-test block.
package mhb_pkg;

	// Delay-line soft reset sequencer.
	typedef enum logic
	{
		DLL_IDLE = 1'b0,
		DLL_RUN  = 1'b1
	} mhb_dll_state_t;

	// Link-side data engine.
	typedef enum logic [2:0]
	{
		L_IDLE = 3'b000,
		L_SEND = 3'b001,
		L_WCRC = 3'b010,
		L_CRC  = 3'b011,
		L_WRD  = 3'b100,
		L_READ = 3'b101
	} mhb_link_state_t;

	// Request passed to the link domain.
	typedef struct packed
	{
		logic [5:0] cmd;
	} mhb_req_t;

	// Answer passed back from the link domain.
	typedef struct packed
	{
		logic timeout;
		logic rd;
	} mhb_rsp_t;

endpackage

// *** rtl/mhb_link.sv ***
// Link-clock data engine: bus-test write, status wait and pattern read.
`timescale 1ns/1ps
`default_nettype none
`include "mhb_defs.svh"

module mhb_link
	import mhb_pkg::*;
#(
	parameter int W       = `MHB_BUS_W,
	parameter int DTO_CYC = `MHB_DTO_CYC
)
(
	input  wire logic           link_clk_i,
	input  wire logic           rst_n_i,
	input  wire logic           req_tgl_i,
	input  wire mhb_req_t       req_i,
	input  wire logic [W-1:0]   dat_i,
	output logic [W-1:0]        dat_o,
	output logic                dat_oe_o,
	output logic                rsp_tgl_o,
	output mhb_rsp_t            rsp_o,
	output logic [2*W-1:0]      pat_o
);

	localparam int CW = $clog2(DTO_CYC + 1);
	localparam logic [W-1:0] PAT0 = {(W/2){2'b01}};
	localparam logic [W-1:0] PAT1 = {(W/2){2'b10}};

	mhb_link_state_t st_q, st_d;
	logic [CW-1:0]   cnt_q, cnt_d;
	logic [W-1:0]    dat_q, dat_d;
	logic            oe_q, oe_d;
	logic            tgl_q, tgl_d;
	mhb_rsp_t        rsp_q, rsp_d;
	logic [2*W-1:0]  pat_q, pat_d;
	mhb_req_t        req_q, req_d;
	logic            rq1_q, rq2_q, rq3_q;
	logic [W-1:0]    ds1_q, ds2_q, ds3_q, filt_q;
	logic            req_edge;

	assign req_edge  = rq2_q ^ rq3_q;
	assign dat_o     = dat_q;
	assign dat_oe_o  = oe_q;
	assign rsp_tgl_o = tgl_q;
	assign rsp_o     = rsp_q;
	assign pat_o     = pat_q;

	// Request toggle crosses in two stages; bus lines pass three and only
	// update the filtered copy once the last two stages agree.
	always_ff @(posedge link_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rq1_q  <= 1'b0;
			rq2_q  <= 1'b0;
			rq3_q  <= 1'b0;
			ds1_q  <= '1;
			ds2_q  <= '1;
			ds3_q  <= '1;
			filt_q <= '1;
		end
		else
		begin
			rq1_q <= req_tgl_i;
			rq2_q <= rq1_q;
			rq3_q <= rq2_q;
			ds1_q <= dat_i;
			ds2_q <= ds1_q;
			ds3_q <= ds2_q;
			if (ds2_q == ds3_q)
				filt_q <= ds3_q;
		end
	end

	// Next state of the data engine.
	always_comb
	begin
		st_d  = st_q;
		cnt_d = cnt_q;
		dat_d = dat_q;
		oe_d  = oe_q;
		tgl_d = tgl_q;
		rsp_d = rsp_q;
		pat_d = pat_q;
		req_d = req_q;
		case (st_q)
			L_IDLE:
			begin
				if (req_edge)
				begin
					req_d = req_i;
					cnt_d = '0;
					if (req_i.cmd == `MHB_CMD_BT_WRITE)
					begin
						st_d  = L_SEND;
						dat_d = '0;
						oe_d  = 1'b1;
					end
					else
						st_d = L_WRD;
				end
			end
			L_SEND:
			begin
				cnt_d = cnt_q + 1'b1;
				case (cnt_q)
					CW'(0): dat_d = PAT0;
					CW'(1): dat_d = PAT1;
					CW'(2): dat_d = '1;
					default:
					begin
						// Line released: the status token is awaited.
						oe_d  = 1'b0; // RQ6
						st_d  = L_WCRC;
						cnt_d = '0;
					end
				endcase
			end
			L_WCRC, L_WRD:
			begin
				cnt_d = cnt_q + 1'b1;
				if (!filt_q[0])
				begin
					st_d  = (st_q == L_WCRC) ? L_CRC : L_READ;
					cnt_d = '0;
				end
				else if (cnt_q == CW'(DTO_CYC - 1))
				begin
					// No start bit ever came: report the timeout.
					st_d  = L_IDLE; // RQ7
					tgl_d = ~tgl_q;
					rsp_d = '{timeout: 1'b1, rd: (st_q == L_WRD)};
				end
			end
			L_CRC:
			begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == CW'(`MHB_CRC_TOK_BITS - 1))
				begin
					st_d  = L_IDLE;
					tgl_d = ~tgl_q;
					rsp_d = '{timeout: 1'b0, rd: 1'b0};
				end
			end
			L_READ:
			begin
				cnt_d = cnt_q + 1'b1;
				// A word passes the filter only after standing two link
				// cycles, so the card holds each word for two and only
				// every second filtered value is a fresh word.
				if (cnt_q[0])
					pat_d = {pat_q[W-1:0], filt_q};
				if (cnt_q == CW'(2 * `MHB_BT_WORDS - 1))
				begin
					st_d  = L_IDLE;
					tgl_d = ~tgl_q;
					rsp_d = '{timeout: 1'b0, rd: 1'b1};
				end
			end
			default:
				st_d = L_IDLE;
		endcase
	end

	// Engine registers.
	always_ff @(posedge link_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_q  <= L_IDLE;
			cnt_q <= '0;
			dat_q <= '1;
			oe_q  <= 1'b0;
			tgl_q <= 1'b0;
			rsp_q <= '0;
			pat_q <= '0;
			req_q <= '0;
		end
		else
		begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
			dat_q <= dat_d;
			oe_q  <= oe_d;
			tgl_q <= tgl_d;
			rsp_q <= rsp_d;
			pat_q <= pat_d;
			req_q <= req_d;
		end
	end

	property p_crc_wait;
		@(posedge link_clk_i) disable iff (!rst_n_i)
		(st_q == L_SEND && cnt_q == CW'(3)) |=> (st_q == L_WCRC && !oe_q);
	endproperty
	a_crc_wait: assert property (p_crc_wait) // RQ6
		else $error("write did not release bus to wait for status");

	property p_link_tmo;
		@(posedge link_clk_i) disable iff (!rst_n_i)
		(st_q == L_WCRC && filt_q[0] && cnt_q == CW'(DTO_CYC - 1))
		|=> (st_q == L_IDLE && rsp_q.timeout && (tgl_q != $past(tgl_q)));
	endproperty
	a_link_tmo: assert property (p_link_tmo) // RQ7
		else $error("status wait did not end in a timeout answer");

endmodule
`default_nettype wire

// *** rtl/mhb_host.sv ***
// Card-host delay-line soft reset sequencer and bus-test command control.
`timescale 1ns/1ps
`default_nettype none
`include "mhb_defs.svh"

// Contract
// RQ1: With auto clock gating set at bit 0 of the config word, the completion of a delay-line reset is lost.
// RQ2: A lost completion leaves the reset flag at bit 31 set for good, and later reset requests are ignored.
// RQ3: Software clears auto clock gating before a delay-line reset and sets it again only after completion.
// RQ4: With auto clock gating clear, the reset flag clears itself at completion and new requests are taken.
// RQ5: The bus test is the pair of the write test command followed by the read test command.
// RQ6: After the write test command the block waits for a status token as for a normal block write.
// RQ7: No token comes, so the wait ends by setting the data timeout flag and its interrupt.
// RQ8: Software ignores that timeout, clears it, then issues the read test command.
module mhb_host
	import mhb_pkg::*;
#(
	parameter int W           = `MHB_BUS_W,
	parameter int DLL_RST_CYC = `MHB_DLL_RST_CYC,
	parameter int DTO_CYC     = `MHB_DTO_CYC
)
(
	input  wire logic           clk_i,
	input  wire logic           rst_n_i,
	input  wire logic           ce_i,
	input  wire logic           link_clk_i,
	input  wire logic [31:0]    host_system_config_i,
	input  wire logic           dll_reset_req_i,
	input  wire logic           bt_start_i,
	input  wire logic [5:0]     bt_cmd_i,
	input  wire logic           dto_clr_i,
	input  wire logic [W-1:0]   dat_i,
	output logic [W-1:0]        dat_o,
	output logic                dat_oe_o,
	output logic [31:0]         delay_line_control_o,
	output logic                data_timeout_flag_o,
	output logic                dto_irq_o,
	output logic                bt_busy_o,
	output logic                bt_done_o,
	output logic [2*W-1:0]      bt_pattern_o
);

	localparam int DCW = $clog2(DLL_RST_CYC + 1);
	localparam logic [DCW-1:0] DLL_LAST = DCW'(DLL_RST_CYC - 1);
	localparam int DLL_D = DLL_RST_CYC;

	// Delay-line reset state.
	mhb_dll_state_t dll_st_q, dll_st_d;
	logic [DCW-1:0] dll_cnt_q, dll_cnt_d;
	logic           dll_flag_q, dll_flag_d;
	logic           autoidle;

	// Bus-test state.
	logic           busy_q, busy_d;
	logic           armed_q, armed_d;
	logic           req_tgl_q, req_tgl_d;
	mhb_req_t       req_q, req_d;
	logic           dto_q, dto_d;
	logic           irq_q, irq_d;
	logic           done_q, done_d;
	logic [2*W-1:0] pat_q, pat_d;

	// Crossing from the link domain.
	logic           rs1_q, rs2_q, rs3_q;
	logic           rsp_edge;
	logic           link_tgl;
	mhb_rsp_t       link_rsp;
	logic [2*W-1:0] link_pat;
	logic           cmd_ok;

	assign autoidle = host_system_config_i[`MHB_AUTOIDLE_BIT];
	assign rsp_edge = rs2_q ^ rs3_q;

	// Outputs come straight from registers.
	assign delay_line_control_o = {dll_flag_q, 31'h0};
	assign data_timeout_flag_o  = dto_q;
	assign dto_irq_o            = irq_q;
	assign bt_busy_o            = busy_q;
	assign bt_done_o            = done_q;
	assign bt_pattern_o         = pat_q;

	// The delay-line reset runs for a fixed count. With gating on, the
	// functional clock is cut near the end and the done event is missed,
	// so the flag stays up and blocks every later request until a reset.
	always_comb
	begin
		dll_st_d   = dll_st_q;
		dll_cnt_d  = dll_cnt_q;
		dll_flag_d = dll_flag_q;
		case (dll_st_q)
			DLL_IDLE:
			begin
				// A set flag means a reset is owed; requests are dropped.
				if (dll_reset_req_i && !dll_flag_q) // RQ2
				begin
					dll_st_d   = DLL_RUN;
					dll_cnt_d  = '0;
					dll_flag_d = 1'b1;
				end
			end
			DLL_RUN:
			begin
				if (dll_cnt_q == DLL_LAST)
				begin
					dll_st_d = DLL_IDLE;
					// Completion recorded only while the clock runs.
					if (!autoidle) // RQ1
						dll_flag_d = 1'b0; // RQ4
				end
				else
					dll_cnt_d = dll_cnt_q + 1'b1;
			end
			default:
				dll_st_d = DLL_IDLE;
		endcase
	end

	// Delay-line reset registers, frozen while the clock enable is low.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			dll_st_q   <= DLL_IDLE;
			dll_cnt_q  <= '0;
			dll_flag_q <= 1'b0;
		end
		else if (ce_i)
		begin
			dll_st_q   <= dll_st_d;
			dll_cnt_q  <= dll_cnt_d;
			dll_flag_q <= dll_flag_d;
		end
	end

	// Only the pair is run; a read test before a finished write test would
	// read back nothing meaningful, so it is ignored.
	assign cmd_ok = (bt_cmd_i == `MHB_CMD_BT_WRITE) ||
		(bt_cmd_i == `MHB_CMD_BT_READ && armed_q);

	// Command launch, answer handling and the data timeout flag.
	always_comb
	begin
		busy_d    = busy_q;
		armed_d   = armed_q;
		req_tgl_d = req_tgl_q;
		req_d     = req_q;
		pat_d     = pat_q;
		done_d    = 1'b0;
		dto_d     = dto_q & ~dto_clr_i;
		if (!busy_q && bt_start_i && cmd_ok) // RQ5
		begin
			busy_d    = 1'b1;
			req_d     = '{cmd: bt_cmd_i};
			req_tgl_d = ~req_tgl_q;
		end
		if (busy_q && rsp_edge)
		begin
			busy_d  = 1'b0;
			done_d  = 1'b1;
			// The write test still counts as done even though it timed out.
			armed_d = !link_rsp.rd; // RQ5
			if (link_rsp.rd && !link_rsp.timeout)
				pat_d = link_pat;
			// Set wins over a clear in the same cycle.
			if (link_rsp.timeout)
				dto_d = 1'b1; // RQ7
		end
		irq_d = dto_d; // RQ7
	end

	// Bus-test registers and the answer-toggle synchroniser.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			busy_q    <= 1'b0;
			armed_q   <= 1'b0;
			req_tgl_q <= 1'b0;
			req_q     <= '0;
			dto_q     <= 1'b0;
			irq_q     <= 1'b0;
			done_q    <= 1'b0;
			pat_q     <= '0;
			rs1_q     <= 1'b0;
			rs2_q     <= 1'b0;
			rs3_q     <= 1'b0;
		end
		else if (ce_i)
		begin
			busy_q    <= busy_d;
			armed_q   <= armed_d;
			req_tgl_q <= req_tgl_d;
			req_q     <= req_d;
			dto_q     <= dto_d;
			irq_q     <= irq_d;
			done_q    <= done_d;
			pat_q     <= pat_d;
			rs1_q     <= link_tgl;
			rs2_q     <= rs1_q;
			rs3_q     <= rs2_q;
		end
	end

	// The link engine holds its answer stable until the next request, so
	// the answer words are sampled safely once the toggle has crossed.
	mhb_link #(
		.W       (W),
		.DTO_CYC (DTO_CYC)
	) mhb_link_inst (
		.link_clk_i (link_clk_i),
		.rst_n_i    (rst_n_i),
		.req_tgl_i  (req_tgl_q),
		.req_i      (req_q),
		.dat_i      (dat_i),
		.dat_o      (dat_o),
		.dat_oe_o   (dat_oe_o),
		.rsp_tgl_o  (link_tgl),
		.rsp_o      (link_rsp),
		.pat_o      (link_pat)
	);

	sequence s_dll_start;
		dll_st_q == DLL_IDLE && dll_reset_req_i && !dll_flag_q;
	endsequence

	sequence s_dll_end;
		dll_st_q == DLL_RUN && dll_cnt_q == DLL_LAST;
	endsequence

	property p_dll_len;
		@(posedge clk_i iff ce_i) disable iff (!rst_n_i)
		s_dll_start |-> ##DLL_D s_dll_end;
	endproperty
	a_dll_len: assert property (p_dll_len) // RQ4
		else $error("delay-line reset did not run its full length");

	property p_dll_clear;
		@(posedge clk_i iff ce_i) disable iff (!rst_n_i)
		(s_dll_end ##0 !autoidle) |=> (!dll_flag_q && dll_st_q == DLL_IDLE);
	endproperty
	a_dll_clear: assert property (p_dll_clear) // RQ4
		else $error("reset flag not cleared at completion");

	property p_dll_lost;
		@(posedge clk_i iff ce_i) disable iff (!rst_n_i)
		(s_dll_end ##0 autoidle) |=> (dll_flag_q && dll_st_q == DLL_IDLE)[*2];
	endproperty
	a_dll_lost: assert property (p_dll_lost) // RQ1
		else $error("completion recorded despite clock gating");

	property p_dll_ignore;
		@(posedge clk_i iff ce_i) disable iff (!rst_n_i)
		(dll_flag_q && dll_st_q == DLL_IDLE && dll_reset_req_i)
		|=> (dll_flag_q && dll_st_q == DLL_IDLE);
	endproperty
	a_dll_ignore: assert property (p_dll_ignore) // RQ2
		else $error("stuck reset flag let a new reset start");

	property p_bt_pair;
		@(posedge clk_i iff ce_i) disable iff (!rst_n_i)
		(!busy_q && bt_start_i && bt_cmd_i == `MHB_CMD_BT_READ && !armed_q)
		|=> !busy_q;
	endproperty
	a_bt_pair: assert property (p_bt_pair) // RQ5
		else $error("read test taken without a prior write test");

	property p_bt_dto;
		@(posedge clk_i iff ce_i) disable iff (!rst_n_i)
		(busy_q && rsp_edge && link_rsp.timeout)
		|=> (dto_q && irq_q && done_q && !busy_q)
		##1 (!done_q && (dto_q || $past(dto_clr_i)));
	endproperty
	a_bt_dto: assert property (p_bt_dto) // RQ7
		else $error("timeout answer did not raise flag and interrupt");

	// A taken request raises the flag at once and starts the count.
	property p_dll_set;
		@(posedge clk_i iff ce_i) disable iff (!rst_n_i)
		s_dll_start
		|=> (dll_flag_q && dll_st_q == DLL_RUN && dll_cnt_q == '0);
	endproperty
	a_dll_set: assert property (p_dll_set) // RQ4
		else $error("taken reset request did not raise the flag");

	// Every accepted command flips the request toggle exactly once.
	property p_bt_launch;
		@(posedge clk_i iff ce_i) disable iff (!rst_n_i)
		(!busy_q && bt_start_i && cmd_ok)
		|=> (busy_q && req_tgl_q != $past(req_tgl_q));
	endproperty
	a_bt_launch: assert property (p_bt_launch) // RQ5
		else $error("accepted bus-test command was not launched");

	// The timeout flag and its interrupt hold until software clears them.
	property p_dto_sticky;
		@(posedge clk_i iff ce_i) disable iff (!rst_n_i)
		(dto_q && !dto_clr_i) |=> (dto_q && irq_q);
	endproperty
	a_dto_sticky: assert property (p_dto_sticky) // RQ7
		else $error("data timeout flag fell without a clear");

	// Completion is a single-cycle pulse, so software never counts it twice.
	property p_done_pulse;
		@(posedge clk_i iff ce_i) disable iff (!rst_n_i)
		done_q |=> !done_q;
	endproperty
	a_done_pulse: assert property (p_done_pulse) // RQ7
		else $error("completion pulse lasted more than one cycle");

endmodule
`default_nettype wire

// *** sim/mhb_card_model.sv ***
// Card model: answers a bus-test read with a start bit and two pattern words.
`timescale 1ns/1ps
`default_nettype none
module mhb_card_model
	import mhb_pkg::*;
#(
	parameter int W = 8
)
(
	input  wire logic           link_clk_i,
	input  wire logic           rst_n_i,
	input  wire logic           send_i,
	input  wire logic [2*W-1:0] pat_i,
	output logic [W-1:0]        dat_o,
	output logic                dat_oe_o
);
	logic       send_q;
	logic [3:0] step_q;

	// A toggle of send_i starts a frame; nothing answers a write test.
	always_ff @(posedge link_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			send_q <= 1'b0;
			step_q <= 4'h0;
		end
		else
		begin
			send_q <= send_i;
			if (send_q != send_i)
				step_q <= 4'h1;
			else if (step_q != 4'h0)
				step_q <= (step_q == 4'h8) ? 4'h0 : step_q + 4'h1;
		end
	end

	// Start bit, high word, low word, end bit, each held two link cycles so
	// the host's line filter passes them, then the lines are let go.
	always_comb
	begin
		dat_oe_o = (step_q != 4'h0);
		case (step_q)
			4'h1, 4'h2: dat_o = '0;
			4'h3, 4'h4: dat_o = pat_i[2*W-1:W];
			4'h5, 4'h6: dat_o = pat_i[W-1:0];
			default: dat_o = '1;
		endcase
	end
endmodule
`default_nettype wire

// *** sim/mhb_host_dll_reset_bus_test_tb_top.sv ***
// Testbench: delay-line reset and bus-test pair against a card model.
`timescale 1ns/1ps
`default_nettype none
module mhb_host_dll_reset_bus_test_tb_top;
	import mhb_pkg::*;
	typedef struct packed
	{
		logic        timeout;
		logic [15:0] pattern;
	} mhb_exp_t;
	logic        clk_i = 1'b0;
	logic        link_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [31:0] cfg = '0;
	logic        dll_req = 1'b0;
	logic        bt_start = 1'b0;
	logic [5:0]  bt_cmd = '0;
	logic        dto_clr = 1'b0;
	logic        send = 1'b0;
	logic [15:0] pat = '0;
	logic [7:0]  host_dat;
	logic [7:0]  card_dat;
	logic [7:0]  bus;
	logic        host_oe;
	logic        card_oe;
	logic [31:0] dlc;
	logic        data_timeout_flag;
	logic        irq;
	logic        busy;
	logic        done;
	logic [15:0] patt;
	logic [31:0] seed = 32'h5f;
	logic [15:0] v;
	logic [15:0] pexp = '0;
	logic [5:0]  bad [2] = '{6'h05, 6'h0e};
	logic [7:0]  wexp [4] = '{8'h00, 8'h55, 8'haa, 8'hff};
	int          widx = 0;
	int          failures = 0;
	int          comparisons = 0;
	int          cyc_cnt = 0;
	int          n;
	mhb_exp_t    expq [$];
	mhb_exp_t    e;

	always #12.5 clk_i = ~clk_i;
	always #7.5 link_clk_i = ~link_clk_i;
	// Data lines carry pull-ups, so a released bus reads all ones.
	assign bus = host_oe ? host_dat : (card_oe ? card_dat : '1);

	mhb_host #(.DLL_RST_CYC(8), .DTO_CYC(32)) mhb_host_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
		.link_clk_i(link_clk_i), .host_system_config_i(cfg),
		.dll_reset_req_i(dll_req), .bt_start_i(bt_start),
		.bt_cmd_i(bt_cmd), .dto_clr_i(dto_clr), .dat_i(bus),
		.dat_o(host_dat), .dat_oe_o(host_oe),
		.delay_line_control_o(dlc), .data_timeout_flag_o(data_timeout_flag),
		.dto_irq_o(irq), .bt_busy_o(busy), .bt_done_o(done),
		.bt_pattern_o(patt));

	mhb_card_model #(.W(8)) mhb_card_model_inst (
		.link_clk_i(link_clk_i), .rst_n_i(rst_n_i), .send_i(send),
		.pat_i(pat), .dat_o(card_dat), .dat_oe_o(card_oe));

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		comparisons++;
		if (got !== ex)
		begin
			$display("[ERR] %s expected %h seen %h", nm, ex, got);
			failures++;
		end
	endtask

	task cyc(input int k);
		repeat (k) @(posedge clk_i);
	endtask

	// Waits k edges, then lets that edge's updates land.
	task settle(input int k);
		cyc(k);
		#1;
	endtask

	task start(input logic [5:0] c);
		@(posedge clk_i);
		bt_start <= 1'b1;
		bt_cmd <= c;
		@(posedge clk_i);
		bt_start <= 1'b0;
	endtask

	task dll_pulse;
		@(posedge clk_i);
		dll_req <= 1'b1;
		@(posedge clk_i);
		dll_req <= 1'b0;
	endtask

	// Gating held off over the whole run, so the flag falls by itself.
	task dll_ok;
		dll_pulse;
		settle(1);
		chk("dll flag set", 32'h8000_0000, dlc);
		settle(6);
		chk("dll flag running", 32'h8000_0000, dlc);
		settle(1);
		chk("dll flag cleared", 32'h0, dlc);
	endtask

	task wait_done;
		n = 0;
		while (done !== 1'b1 && n < 3000)
		begin
			@(negedge clk_i);
			n++;
		end
		if (n >= 3000)
		begin
			$display("[ERR] done expected 1 seen 0");
			failures++;
			end_sim;
		end
		cyc(1);
	endtask

	task end_sim;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Each completion is matched against the oldest expectation; sampled
	// mid-cycle because done stands for one clock only.
	always @(negedge clk_i)
	begin
		if (done === 1'b1)
		begin
			if (expq.size() == 0)
				chk("unexpected done", 32'h0, 32'h1);
			else
			begin
				e = expq.pop_front();
				chk("timeout flag", 32'(e.timeout), 32'(data_timeout_flag));
				chk("interrupt", 32'(e.timeout), 32'(irq));
				chk("pattern", 32'(e.pattern), 32'(patt));
			end
		end
	end

	// Write test goes out like a block write: start, 55, aa, end.
	always @(negedge link_clk_i)
	begin
		if (host_oe === 1'b1)
		begin
			chk("bus word", 32'(wexp[widx]), 32'(host_dat));
			widx = (widx + 1) % 4;
		end
	end

	always @(posedge clk_i)
	begin
		cyc_cnt++;
		if (cyc_cnt == 20000)
		begin
			failures++;
			end_sim;
		end
	end

	initial
	begin
		cyc(3);
		rst_n_i <= 1'b1;
		foreach (bad[i])
		begin
			start(bad[i]);
			settle(3);
			chk("busy after refused", 32'h0, 32'(busy));
		end
		$display("test refused commands done");
		repeat (2)
		begin
			expq.push_back('{1'b1, pexp});
			start(6'h13);
			#1;
			chk("busy", 32'h1, 32'(busy));
			wait_done;
			settle(2);
			chk("flag sticky", 32'h1, 32'(data_timeout_flag));
			@(posedge clk_i);
			dto_clr <= 1'b1;
			@(posedge clk_i);
			dto_clr <= 1'b0;
			settle(1);
			chk("flag cleared", 32'h0, 32'(data_timeout_flag) | 32'(irq));
			v = 16'(xs());
			@(posedge clk_i);
			pat <= v;
			expq.push_back('{1'b0, v});
			pexp = v;
			start(6'h0e);
			cyc(6);
			send <= ~send;
			wait_done;
		end
		start(6'h0e);
		settle(3);
		chk("busy after disarmed read", 32'h0, 32'(busy));
		$display("test bus pair done");
		repeat (2)
		begin
			@(posedge clk_i);
			cfg <= xs() & 32'hffff_fffe;
			dll_ok;
		end
		$display("test dll reset done");
		dll_pulse;
		cyc(2);
		cfg <= xs() | 32'h1;
		settle(20);
		chk("dll flag stuck", 32'h8000_0000, dlc);
		dll_pulse;
		settle(20);
		chk("dll flag still stuck", 32'h8000_0000, dlc);
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		cfg <= '0;
		cyc(3);
		rst_n_i <= 1'b1;
		settle(1);
		chk("dll flag after reset", 32'h0, dlc);
		dll_ok;
		$display("test lost completion done");
		chk("pending results", 32'h0, 32'(expq.size()));
		end_sim;
	end
endmodule
`default_nettype wire
